// ===== src/aspo_link_if.sv
// Signals between the bus-side control and the link-side serializer
`timescale 1ns/1ps
interface aspo_link_if;
  import aspo_pkg::*;
  logic [ASPO_WORD_W-1:0] word;
  logic req_tgl;
  logic [ASPO_LCFG_W-1:0] cfg;
  logic ack_tgl;
  modport ctl (output word, output req_tgl, output cfg, input ack_tgl);
  modport lnk (input word, input req_tgl, input cfg, output ack_tgl);
endinterface

// ===== src/aspo_pkg.sv
// Constants and types shared by the serial output port of the converter
//
// Operation
// - Clock edge select picks the data-valid edge
// - Rate select: serial clock full or half
// - Word rate select high gives low rate
// - High rate decimates sixteen, low thirty-two
// - Filter select high low-pass, low band-pass
// - Time slot sets the enable's active level
// - Frame sync marks each word's start
// - Frame sync pulse or low over data
// - MSB first, 32 clocks, trailing zeros
// - Frame sync input realigns the output word
package aspo_pkg;

  // ----------------------------------------------------------------------
  // Word framing
  // ----------------------------------------------------------------------
  localparam int ASPO_WORD_W = 16;
  localparam logic [4:0] ASPO_LAST_SLOT = 5'h1F;
  localparam logic [4:0] ASPO_TRAIL_SLOT = 5'h10;
  localparam logic [5:0] ASPO_DECIM_HIGH = 6'h10;
  localparam logic [5:0] ASPO_DECIM_LOW = 6'h20;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [31:0] ASPO_CTRL_OFS = 32'h0000_0000;
  localparam logic [31:0] ASPO_STAT_OFS = 32'h0000_0004;
  localparam logic [31:0] ASPO_WORD_OFS = 32'h0000_0008;
  localparam int ASPO_CTRL_W = 7;
  localparam logic [6:0] ASPO_CTRL_RST = 7'h00;
  localparam int ASPO_CTRL_EDGE = 0;
  localparam int ASPO_CTRL_RATE = 1;
  localparam int ASPO_CTRL_WRATE = 2;
  localparam int ASPO_CTRL_FILT = 3;
  localparam int ASPO_CTRL_FMT = 4;
  localparam int ASPO_CTRL_TSLOT = 5;
  localparam int ASPO_CTRL_EN = 6;
  localparam int ASPO_STAT_BUSY = 0;
  localparam int ASPO_STAT_OVR = 1;
  localparam int ASPO_STAT_CNT = 16;
  localparam logic [1:0] ASPO_RESP_OKAY = 2'h0;
  localparam logic [1:0] ASPO_RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------------
  // Link-side configuration bits
  // ----------------------------------------------------------------------
  localparam int ASPO_LCFG_W = 4;
  localparam int ASPO_LCFG_EDGE = 0;
  localparam int ASPO_LCFG_RATE = 1;
  localparam int ASPO_LCFG_FMT = 2;
  localparam int ASPO_LCFG_TSLOT = 3;

  // Bus-side state
  typedef struct packed {
    logic aw_full;
    logic [31:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [6:0] ctrl;
    logic overrun;
    logic [15:0] word_cnt;
    logic [15:0] word;
    logic req_tgl;
  } aspo_ctl_t;

  // Link-side state
  typedef struct packed {
    logic div;
    logic [4:0] slot;
    logic [15:0] shreg;
    logic active;
    logic fsync;
    logic oe;
    logic req_seen;
    logic ack_tgl;
    logic sync_in_prev;
    logic realign_pend;
  } aspo_lnk_t;

endpackage

// ===== src/aspo_serializer.sv
// Link-side serializer running on the master clock
`timescale 1ns/1ps
module aspo_serializer
  import aspo_pkg::*;
(
  input wire logic master_clock_in,
  input wire logic aresetn,
  aspo_link_if.lnk lnk,
  input wire logic frame_sync_in,
  input wire logic data_output_enable,
  output logic serial_clock_out,
  output logic serial_data_out,
  output logic serial_data_oe,
  output logic frame_sync_out
);
  aspo_lnk_t st_r;
  aspo_lnk_t st_nxt;
  logic lrst_n;
  logic [6:0] sync_q;
  logic req_s;
  logic edge_s;
  logic half_s;
  logic fmt_s;
  logic tslot_s;
  logic sync_in_s;
  logic en_pin_s;
  logic tick;
  logic [4:0] slot_inc;

  // ----------------------------------------------------------------------
  // Crossings into the master clock domain
  // ----------------------------------------------------------------------
  aspo_sync #(.W(1)) u_rst_sync (
    .clk(master_clock_in),
    .rst_n(1'b1),
    .d(aresetn),
    .q(lrst_n)
  );

  aspo_sync #(.W(7)) u_in_sync (
    .clk(master_clock_in),
    .rst_n(lrst_n),
    .d({lnk.req_tgl, lnk.cfg, frame_sync_in, data_output_enable}),
    .q(sync_q)
  );

  // Selects are static levels; a change reaches them four master edges later, through the synchroniser
  assign req_s = sync_q[6];
  assign edge_s = sync_q[2 + ASPO_LCFG_EDGE];
  assign half_s = sync_q[2 + ASPO_LCFG_RATE];
  assign fmt_s = sync_q[2 + ASPO_LCFG_FMT];
  assign tslot_s = sync_q[2 + ASPO_LCFG_TSLOT];
  assign sync_in_s = sync_q[1];
  assign en_pin_s = sync_q[0];

  // ----------------------------------------------------------------------
  // Bit timing, framing and shifting
  // ----------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    slot_inc = st_r.slot + 5'h01;
    tick = half_s ? ~st_r.div : 1'b1;
    st_nxt.div = half_s ? ~st_r.div : 1'b0;
    st_nxt.sync_in_prev = sync_in_s;
    st_nxt.oe = (en_pin_s == tslot_s);
    if (tick) begin
      if (st_r.realign_pend) begin
        st_nxt.realign_pend = 1'b0;
        st_nxt.active = 1'b0;
        st_nxt.slot = 5'h00;
        st_nxt.shreg = '0;
        st_nxt.fsync = fmt_s;
      end else if (!st_r.active || st_r.slot == ASPO_LAST_SLOT) begin
        if (req_s != st_r.req_seen) begin
          st_nxt.shreg = lnk.word;
          st_nxt.active = 1'b1;
          st_nxt.slot = 5'h00;
          st_nxt.req_seen = req_s;
          st_nxt.ack_tgl = req_s;
          st_nxt.fsync = ~fmt_s;
        end else begin
          st_nxt.active = 1'b0;
          st_nxt.slot = 5'h00;
          st_nxt.shreg = '0;
          st_nxt.fsync = fmt_s;
        end
      end else begin
        st_nxt.slot = slot_inc;
        st_nxt.shreg = {st_r.shreg[ASPO_WORD_W-2:0], 1'b0};
        st_nxt.fsync = fmt_s ? (slot_inc >= ASPO_TRAIL_SLOT) : 1'b0;
      end
    end
    // A new edge on frame sync in wins over the consume above
    if (sync_in_s && !st_r.sync_in_prev) begin
      st_nxt.realign_pend = 1'b1;
    end
  end

  // State register
  always_ff @(posedge master_clock_in) begin
    if (!lrst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Data changes on the base rising edge; inversion moves the valid edge
  assign serial_clock_out = (half_s ? st_r.div : master_clock_in) ^ edge_s;
  assign serial_data_out = st_r.shreg[ASPO_WORD_W-1];
  assign serial_data_oe = st_r.oe;
  assign frame_sync_out = st_r.fsync;
  assign lnk.ack_tgl = st_r.ack_tgl;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  half_step_a: assert property (@(posedge master_clock_in) disable iff (!lrst_n)
    (half_s && tick) ##1 half_s |-> !tick)
    else $error("half rate serial clock shifted on two master edges in a row");

  edge_valid_a: assert property (@(posedge master_clock_in) disable iff (!lrst_n)
    (half_s && tick && $stable(edge_s)) ##1 half_s |-> (serial_clock_out == ~edge_s))
    else $error("serial clock not at launch level after a data change");

  load_word_a: assert property (@(posedge master_clock_in) disable iff (!lrst_n)
    (tick && !st_r.realign_pend && (!st_r.active || st_r.slot == ASPO_LAST_SLOT)
     && req_s != st_r.req_seen) |=> (serial_data_out == $past(lnk.word[15])))
    else $error("word not loaded most significant bit first");

  trail_zero_a: assert property (@(posedge master_clock_in) disable iff (!lrst_n)
    (st_r.active && st_r.slot >= ASPO_TRAIL_SLOT) |-> (serial_data_out == 1'b0))
    else $error("trailing slots not zero");

  pulse_start_a: assert property (@(posedge master_clock_in) disable iff (!lrst_n)
    ($rose(st_r.active) && !$past(fmt_s) && !fmt_s) |-> frame_sync_out)
    else $error("frame pulse missing at word start");

  frame_low_a: assert property (@(posedge master_clock_in) disable iff (!lrst_n)
    (fmt_s && $stable(fmt_s) && st_r.active && st_r.slot < ASPO_TRAIL_SLOT)
    |-> !frame_sync_out)
    else $error("frame sync not low during data bits");

  realign_a: assert property (@(posedge master_clock_in) disable iff (!lrst_n)
    (st_r.realign_pend && tick) |=> (!st_r.active && st_r.slot == 5'h00))
    else $error("frame sync input did not realign the output word");

  enable_level_a: assert property (@(posedge master_clock_in) disable iff (!lrst_n)
    ($changed(en_pin_s) && $stable(tslot_s))
    |=> (serial_data_oe == ($past(en_pin_s) == $past(tslot_s))))
    else $error("output enable level does not follow time slot");
endmodule

// ===== src/aspo_sync.sv
// Three-stage synchroniser that passes a change once stages two and three agree
`timescale 1ns/1ps
module aspo_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } aspo_sync_t;

  aspo_sync_t st_r;
  aspo_sync_t st_nxt;

  // Shift chain; output follows only agreed bits
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.q = (st_r.s2 & ~(st_r.s2 ^ st_r.s3)) | (st_r.q & (st_r.s2 ^ st_r.s3));
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.q;
endmodule

// ===== src/aspo_top.sv
// Bus-side control of the converter serial output port with AXI4-Lite registers
//
// Design decisions made here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module aspo_top
  import aspo_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Decimation filter side
  input wire logic [15:0] stage4_data,
  input wire logic stage4_valid,
  input wire logic [15:0] stage5_data,
  input wire logic stage5_valid,
  output logic filter_lowpass,
  output logic [5:0] decimation_ratio,
  // Serial link
  input wire logic master_clock_in,
  input wire logic frame_sync_in,
  input wire logic data_output_enable,
  output logic serial_clock_out,
  output logic serial_data_out,
  output logic serial_data_oe,
  output logic frame_sync_out
);
  aspo_ctl_t st_r;
  aspo_ctl_t st_nxt;
  aspo_link_if lnk_if ();
  logic ack_s;
  logic wr_fire;
  logic rd_fire;
  logic busy;
  logic sel_valid;
  logic [15:0] sel_data;
  logic [31:0] stat_word;

  // ----------------------------------------------------------------------
  // Acknowledge crossing back from the link domain
  // ----------------------------------------------------------------------
  aspo_sync #(.W(1)) u_ack_sync (
    .clk(aclk),
    .rst_n(aresetn),
    .d(lnk_if.ack_tgl),
    .q(ack_s)
  );

  // ----------------------------------------------------------------------
  // Link-side serializer
  // ----------------------------------------------------------------------
  aspo_serializer u_ser (
    .master_clock_in(master_clock_in),
    .aresetn(aresetn),
    .lnk(lnk_if.lnk),
    .frame_sync_in(frame_sync_in),
    .data_output_enable(data_output_enable),
    .serial_clock_out(serial_clock_out),
    .serial_data_out(serial_data_out),
    .serial_data_oe(serial_data_oe),
    .frame_sync_out(frame_sync_out)
  );

  // Word and configuration handed to the link domain
  assign lnk_if.word = st_r.word;
  assign lnk_if.req_tgl = st_r.req_tgl;
  assign lnk_if.cfg = {st_r.ctrl[ASPO_CTRL_TSLOT], st_r.ctrl[ASPO_CTRL_FMT],
                       st_r.ctrl[ASPO_CTRL_RATE], st_r.ctrl[ASPO_CTRL_EDGE]};

  // ----------------------------------------------------------------------
  // Bus handshakes and word source selection
  // ----------------------------------------------------------------------
  assign s_axi_awready = ~st_r.aw_full;
  assign s_axi_wready = ~st_r.w_full;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = ~st_r.rvalid;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rresp = st_r.rresp;
  assign s_axi_rdata = st_r.rdata;

  assign wr_fire = st_r.aw_full & st_r.w_full & ~st_r.bvalid;
  assign rd_fire = s_axi_arvalid & ~st_r.rvalid;
  assign busy = st_r.req_tgl ^ ack_s;

  // High word rate from stage four, low word rate from stage five
  assign sel_valid = st_r.ctrl[ASPO_CTRL_WRATE] ? stage5_valid : stage4_valid;
  assign sel_data = st_r.ctrl[ASPO_CTRL_WRATE] ? stage5_data : stage4_data;

  // Filter configuration for the decimator
  assign filter_lowpass = st_r.ctrl[ASPO_CTRL_FILT];
  assign decimation_ratio = st_r.ctrl[ASPO_CTRL_WRATE] ? ASPO_DECIM_LOW : ASPO_DECIM_HIGH;

  // Status word view
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[ASPO_STAT_BUSY] = busy;
    stat_word[ASPO_STAT_OVR] = st_r.overrun;
    stat_word[ASPO_STAT_CNT +: 16] = st_r.word_cnt;
  end

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // Address and data are taken in either order
    if (s_axi_awvalid && !st_r.aw_full) begin
      st_nxt.aw_full = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_r.w_full) begin
      st_nxt.w_full = 1'b1;
      st_nxt.w_data = s_axi_wdata;
      st_nxt.w_strb = s_axi_wstrb;
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    // Write decode; only byte lane zero carries writable bits
    if (wr_fire) begin
      st_nxt.aw_full = 1'b0;
      st_nxt.w_full = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = ASPO_RESP_OKAY;
      if (st_r.aw_addr == ASPO_CTRL_OFS) begin
        if (st_r.w_strb[0]) begin
          st_nxt.ctrl = st_r.w_data[ASPO_CTRL_W-1:0];
        end
      end else if (st_r.aw_addr == ASPO_STAT_OFS) begin
        if (st_r.w_strb[0] && st_r.w_data[ASPO_STAT_OVR]) begin
          st_nxt.overrun = 1'b0;
        end
      end else if (st_r.aw_addr == ASPO_WORD_OFS) begin
        st_nxt.bresp = ASPO_RESP_OKAY;
      end else begin
        st_nxt.bresp = ASPO_RESP_SLVERR;
      end
    end
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    // Read decode; unmapped reads answer zero with an error
    if (rd_fire) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = ASPO_RESP_OKAY;
      if (s_axi_araddr == ASPO_CTRL_OFS) begin
        st_nxt.rdata = {25'h0000000, st_r.ctrl};
      end else if (s_axi_araddr == ASPO_STAT_OFS) begin
        st_nxt.rdata = stat_word;
      end else if (s_axi_araddr == ASPO_WORD_OFS) begin
        st_nxt.rdata = {16'h0000, st_r.word};
      end else begin
        st_nxt.rdata = 32'h0000_0000;
        st_nxt.rresp = ASPO_RESP_SLVERR;
      end
    end
    // Word capture; a word arriving while one is in flight is an overrun
    if (st_r.ctrl[ASPO_CTRL_EN] && sel_valid) begin
      if (!busy) begin
        st_nxt.word = sel_data;
        st_nxt.req_tgl = ~st_r.req_tgl;
        st_nxt.word_cnt = st_r.word_cnt + 16'h0001;
      end else begin
        st_nxt.overrun = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
      st_r.ctrl <= ASPO_CTRL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  filter_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_fire && st_r.aw_addr == ASPO_CTRL_OFS && st_r.w_strb[0])
    |=> (filter_lowpass == $past(st_r.w_data[ASPO_CTRL_FILT])))
    else $error("filter select did not follow control write");

  low_rate_src_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r.ctrl[ASPO_CTRL_EN] && st_r.ctrl[ASPO_CTRL_WRATE] && stage5_valid && !busy)
    |=> (st_r.word == $past(stage5_data) && decimation_ratio == ASPO_DECIM_LOW))
    else $error("low word rate not taken from stage five");

  high_rate_src_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r.ctrl[ASPO_CTRL_EN] && !st_r.ctrl[ASPO_CTRL_WRATE] && stage4_valid && !busy)
    |=> (st_r.word == $past(stage4_data) && decimation_ratio == ASPO_DECIM_HIGH))
    else $error("high word rate not taken from stage four");

  read_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_fire |=> (s_axi_rvalid && !s_axi_arready))
    else $error("read not answered in one cycle");

  write_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire |=> (s_axi_bvalid && !s_axi_awready == 1'b0))
    else $error("write not answered in one cycle");
endmodule

// ===== verif/aspo_dsp_rx.sv
// Receiving serial port model that captures words from the converter link
`timescale 1ns/1ps
module aspo_dsp_rx (
  input wire logic sclk,
  input wire logic sdata,
  input wire logic fsync,
  input wire logic edge_sel,
  input wire logic fmt,
  output logic [31:0] data_v,
  output logic [31:0] fsync_v,
  output logic [15:0] n_words
);
  logic [31:0] dsh = 32'h0;
  logic [31:0] fsh = 32'h0;
  logic [5:0] idx = 6'h00;
  logic prev_fsync = 1'b0;
  logic smp;

  // Sample on the falling edge of the serial clock, or the rising one when selected
  assign smp = sclk ~^ edge_sel;

  initial begin
    data_v = 32'h0;
    fsync_v = 32'h0;
    n_words = 16'h0;
  end

  // A word opens on the rise of a high pulse, or on the fall of the frame level
  // A frame level still high after a format change opens nothing
  // Bits arrive most significant first, 32 slots to a word
  always @(posedge smp) begin
    prev_fsync <= fsync;
    if (idx == 6'h00 && (fmt ? (prev_fsync && !fsync) : (!prev_fsync && fsync))) begin
      idx <= 6'h01;
      dsh <= {31'h0, sdata};
      fsh <= {31'h0, fsync};
    end else if (idx == 6'h1F) begin
      idx <= 6'h00;
      data_v <= {dsh[30:0], sdata};
      fsync_v <= {fsh[30:0], fsync};
      n_words <= n_words + 16'h1;
    end else if (idx != 6'h00) begin
      idx <= idx + 6'h01;
      dsh <= {dsh[30:0], sdata};
      fsh <= {fsh[30:0], fsync};
    end
  end
endmodule

// ===== verif/tb_top.sv
// Self-checking bench for the converter serial output port
`timescale 1ns/1ps
module tb_top;
  import aspo_pkg::*;
  logic aclk = 1'b0;
  logic master_clock_in = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [31:0] s_axi_araddr = 32'h0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic [15:0] stage4_data = 16'h0;
  logic stage4_valid = 1'b0;
  logic [15:0] stage5_data = 16'h0;
  logic stage5_valid = 1'b0;
  logic filter_lowpass;
  logic [5:0] decimation_ratio;
  logic frame_sync_in = 1'b0;
  logic data_output_enable = 1'b0;
  logic serial_clock_out;
  logic serial_data_out;
  logic serial_data_oe;
  logic frame_sync_out;
  logic line_w = 1'b0;
  logic line_last = 1'b0;
  logic p_edge = 1'b0;
  logic p_fmt = 1'b0;
  logic [31:0] data_v;
  logic [31:0] fsync_v;
  logic [15:0] n_words;
  int err_count = 0;
  int n_checks = 0;

  // -------------------------------------------------------------------------
  // Clocks, line and instances
  // -------------------------------------------------------------------------
  always #12.5 aclk = ~aclk;
  always #80 master_clock_in = ~master_clock_in;

  // Released data line shows the inverse of the last driven bit
  always @(serial_data_out, serial_data_oe) begin
    if (serial_data_oe) begin
      line_last = serial_data_out;
    end
    line_w = serial_data_oe ? serial_data_out : ~line_last;
  end

  aspo_top aspo_top_i (.*);

  aspo_dsp_rx aspo_dsp_rx_i (
    .sclk(serial_clock_out),
    .sdata(line_w),
    .fsync(frame_sync_out),
    .edge_sel(p_edge),
    .fmt(p_fmt),
    .data_v(data_v),
    .fsync_v(fsync_v),
    .n_words(n_words)
  );

  // -------------------------------------------------------------------------
  // Tasks
  // -------------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Write one word and compare the response code
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw;
    logic w;
    logic b;
    logic [1:0] r;
    b = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b) begin
      @(negedge aclk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    check("bresp", 32'(er), 32'(r));
  endtask

  // Read one word and compare data and response code
  task automatic rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar;
    logic got;
    logic [31:0] d;
    logic [1:0] r;
    got = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!got) begin
      @(negedge aclk);
      ar = s_axi_arvalid && s_axi_arready;
      got = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    check("rresp", 32'(er), 32'(r));
    check("rdata", ed, d);
  endtask

  // Offer one word from each decimation stage for a single cycle
  task automatic send_word(input logic [15:0] d4, input logic [15:0] d5);
    @(posedge aclk);
    stage4_data <= d4;
    stage5_data <= d5;
    stage4_valid <= 1'b1;
    stage5_valid <= 1'b1;
    @(posedge aclk);
    stage4_valid <= 1'b0;
    stage5_valid <= 1'b0;
  endtask

  // Wait, bounded, until the receiver has taken one more word
  task automatic wait_word();
    logic [15:0] n0;
    int k;
    n0 = n_words;
    k = 0;
    while (n_words == n0 && k < 3000) begin
      @(posedge aclk);
      k++;
    end
    check("word seen", 32'h1, 32'(n_words != n0));
  endtask

  // -------------------------------------------------------------------------
  // Tests
  // -------------------------------------------------------------------------
  initial begin
    repeat (40000) @(posedge aclk);
    err_count++;
    give_verdict();
  end

  initial begin
    int i;
    int c;
    int n_acc;
    logic [6:0] ctrl;
    logic [15:0] ew;
    realtime t0;
    n_acc = 0;
    // Long enough for the link side to see the reset as well
    repeat (60) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (20) @(posedge aclk);
    rd(ASPO_CTRL_OFS, 32'h0, ASPO_RESP_OKAY);
    rd(32'h0000_0010, 32'h0, ASPO_RESP_SLVERR);
    wr(32'h0000_0010, 32'h0, ASPO_RESP_SLVERR);
    // Enable polarity follows the slot setting
    for (i = 0; i < 4; i++) begin
      wr(ASPO_CTRL_OFS, 32'(i[1]) << ASPO_CTRL_TSLOT, ASPO_RESP_OKAY);
      data_output_enable <= i[0];
      repeat (100) @(posedge aclk);
      check("oe", 32'(i[1] == i[0]), 32'(serial_data_oe));
    end
    data_output_enable <= 1'b0;
    // Every combination of edge, rate, word rate and frame format
    for (c = 0; c < 16; c++) begin
      ctrl = 7'h40;
      ctrl[ASPO_CTRL_EDGE] = c[0];
      ctrl[ASPO_CTRL_RATE] = c[1];
      ctrl[ASPO_CTRL_WRATE] = c[2];
      ctrl[ASPO_CTRL_FMT] = c[3];
      ctrl[ASPO_CTRL_FILT] = c[0] ^ c[2];
      wr(ASPO_CTRL_OFS, 32'(ctrl), ASPO_RESP_OKAY);
      p_edge <= c[0];
      p_fmt <= c[3];
      repeat (100) @(posedge aclk);
      check("ratio", c[2] ? 32'h20 : 32'h10, 32'(decimation_ratio));
      check("lowpass", 32'(c[0] ^ c[2]), 32'(filter_lowpass));
      @(posedge serial_clock_out);
      t0 = $realtime;
      @(posedge serial_clock_out);
      check("sclk period", c[1] ? 32'h140 : 32'hA0, 32'($rtoi($realtime - t0)));
      ew = c[2] ? (16'h3C5A ^ 16'(c << 4)) : (16'hA5C3 ^ 16'(c));
      send_word(16'hA5C3 ^ 16'(c), 16'h3C5A ^ 16'(c << 4));
      n_acc++;
      wait_word();
      check("data", {ew, 16'h0}, data_v);
      check("fsync", c[3] ? 32'h0000_FFFF : 32'h8000_0000, fsync_v);
      rd(ASPO_WORD_OFS, 32'(ew), ASPO_RESP_OKAY);
    end
    // Word offered while one is in flight is dropped and flagged
    wr(ASPO_CTRL_OFS, 32'h40, ASPO_RESP_OKAY);
    p_edge <= 1'b0;
    p_fmt <= 1'b0;
    repeat (100) @(posedge aclk);
    send_word(16'h1234, 16'h0);
    send_word(16'hFFFF, 16'h0);
    n_acc++;
    repeat (10) @(posedge aclk);
    rd(ASPO_STAT_OFS, {16'(n_acc), 16'h0003}, ASPO_RESP_OKAY);
    wait_word();
    check("data", 32'h1234_0000, data_v);
    repeat (50) @(posedge aclk);
    wr(ASPO_STAT_OFS, 32'h2, ASPO_RESP_OKAY);
    rd(ASPO_STAT_OFS, {16'(n_acc), 16'h0000}, ASPO_RESP_OKAY);
    wr(ASPO_WORD_OFS, 32'hFFFF, ASPO_RESP_OKAY);
    rd(ASPO_WORD_OFS, 32'h1234, ASPO_RESP_OKAY);
    // Frame sync input cuts a word short, the next one arrives whole
    send_word(16'hBEEF, 16'h0);
    repeat (60) @(posedge aclk);
    frame_sync_in <= 1'b1;
    repeat (20) @(posedge aclk);
    frame_sync_in <= 1'b0;
    repeat (400) @(posedge aclk);
    check("cut word", 32'h0, 32'(data_v == 32'hBEEF_0000));
    send_word(16'h5A5A, 16'h0);
    n_acc += 2;
    wait_word();
    check("data", 32'h5A5A_0000, data_v);
    check("fsync", 32'h8000_0000, fsync_v);
    repeat (50) @(posedge aclk);
    rd(ASPO_STAT_OFS, {16'(n_acc), 16'h0000}, ASPO_RESP_OKAY);
    give_verdict();
  end
endmodule
